/* crchr_cfg.svh */
/*
 * Constants of the rotate-carry / hub-read execute block: opcodes,
 * instruction fields, register offsets, flag bits and cycle counts.
 * Assumes it is included by bare name, before any use of its macros.
 */
`ifndef CRCHR_CFG_SVH
`define CRCHR_CFG_SVH

// Opcode values of the handled instructions
`define CRCHR_OP_ROL    6'h0d
`define CRCHR_OP_ROR    6'h0c
`define CRCHR_OP_RBYTE  6'h00
`define CRCHR_OP_RLONG  6'h02

// Instruction word fields
`define CRCHR_F_OP 31:26
`define CRCHR_F_ZE 25
`define CRCHR_F_CE 24
`define CRCHR_F_WR 23
`define CRCHR_F_IM 22
`define CRCHR_F_D  17:9
`define CRCHR_F_S  8:0
`define CRCHR_F_CNT 4:0

// Operand addresses of the phase accumulators
`define CRCHR_PHSA_ADR 9'h1fc
`define CRCHR_PHB_ADR  9'h1fd

// Register byte offsets
`define CRCHR_A_INSTR  8'h00
`define CRCHR_A_DVAL   8'h04
`define CRCHR_A_SVAL   8'h08
`define CRCHR_A_FLAGS  8'h0c
`define CRCHR_A_RESULT 8'h10
`define CRCHR_A_STATUS 8'h14
`define CRCHR_A_CTLA   8'h18
`define CRCHR_A_INCA   8'h1c
`define CRCHR_A_CTLB   8'h20
`define CRCHR_A_INCB   8'h24
`define CRCHR_A_PHSA   8'h28
`define CRCHR_A_PHB    8'h2c

// Bit positions in FLAGS and STATUS
`define CRCHR_FLG_C  0
`define CRCHR_FLG_Z  1
`define CRCHR_ST_BSY 0
`define CRCHR_ST_ERR 1
`define CRCHR_ST_WRO 2

// Counter mode field of a control register
`define CRCHR_CTR_MODE 30:26

// Cycle counts and misc values
`define CRCHR_ROT_CLKS 5'h04
`define CRCHR_HUB_MIN  5'h07
`define CRCHR_CNT_MAX  5'h1f
`define CRCHR_ZERO32   32'h0000_0000
`define CRCHR_ONES32   32'hffff_ffff
`define CRCHR_RESP_OK  2'h0
`define CRCHR_RESP_ERR 2'h2

`endif

/* crchr_pkg.sv */
/*
 * Types shared by the execute block.
 * Assumes nothing of its surroundings.
 */
package crchr_pkg;

    // Execution state, one-hot
    typedef enum logic [2:0]
    {
        CRCHR_ST_IDLE = 3'b001,
        CRCHR_ST_ROT  = 3'b010,
        CRCHR_ST_HUB  = 3'b100
    } crchr_state_t;

endpackage : crchr_pkg

/* crchr_ctr_if.sv */
/*
 * Link between the execute block and one counter module.
 * Assumes a single clock shared by both ends.
 */
`timescale 1ns/100ps
interface crchr_ctr_if;
    logic [31:0] ctrl;
    logic [31:0] frq;
    logic [31:0] wdata;
    logic        wr;
    logic [31:0] phs;

    modport owner (output ctrl, output frq, output wdata, output wr, input phs);
    modport ctr   (input ctrl, input frq, input wdata, input wr, output phs);
endinterface : crchr_ctr_if

/* crchr_phase_ctr.sv */
/*
 * One counter module: a phase accumulator stepping by its increment.
 * Assumes the owner pulses wr for one cycle with wdata valid.
 */
`timescale 1ns/100ps
`include "crchr_cfg.svh"
module crchr_phase_ctr (
    input  wire logic   aclk,
    input  wire logic   aresetn,
    crchr_ctr_if.ctr    port
);

    // A write wins over accumulation so software sees its own value
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            port.phs <= `CRCHR_ZERO32;
        else if (port.wr)
            port.phs <= port.wdata;
        else if (port.ctrl[`CRCHR_CTR_MODE] != 5'h00)
            port.phs <= port.phs + port.frq;
    end

endmodule : crchr_phase_ctr

/* crchr_top.sv */
/*
 * Execute-stage slice: rotate-through-carry, byte/long hub reads and
 * the phase accumulator operand behaviour, driven over AXI4-Lite.
 * Assumes a hub arbiter on aclk that pulses hub_gnt with hub_rdata.
 */
// Functional notes
// - Two identical counters, each with control, increment and phase register.
// - Each phase accumulator adds its increment per its mode.
// - Phase address as source reads the live accumulator.
// - Phase address as destination reads shadow; writes update shadow and accumulator.
// - Rotate-left opcode 001101, finishes in four clocks.
// - Rotate-left fills vacated low bits with the prior carry.
// - Rotate count from register or immediate, five bits used.
// - Carry-write on rotate-left gives original destination bit 31.
// - Zero-write sets zero on zero result; result stored unless no-write.
// - Rotate-right opcode 001100, finishes in four clocks.
// - Rotate-right fills vacated high bits with the prior carry.
// - Carry-write on rotate-right gives original destination bit 0.
// - Byte read opcode 000000 waits for hub, stores zero-extended byte.
// - Long read opcode 000010 waits for hub, stores 32-bit long.
// - Long read clears the two lowest address bits.
// - Read address from register or 9-bit immediate.
// - Hub reads take 7 to 22 clocks depending on slot.
// - Hub read zero-write flags zero data; carry result is zero.
// - Hub reads always write; no-write form is a write instruction (here refused as unknown, STATUS error bit set).
`timescale 1ns/100ps
`include "crchr_cfg.svh"
module crchr_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             hub_req,
    output logic [15:0]      hub_addr,
    output logic             hub_long,
    input  wire logic        hub_gnt,
    input  wire logic [31:0] hub_rdata
);

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] f_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction : f_merge

    // True for every offset that holds a register
    function automatic logic f_mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= `CRCHR_A_PHB);
    endfunction : f_mapped

    // Rotate left, carry fills the vacated low bits
    function automatic logic [31:0] f_rol(input logic [31:0] d, input logic [4:0] n,
                                          input logic c);
        return (d << n) | (c ? ~(`CRCHR_ONES32 << n) : `CRCHR_ZERO32);
    endfunction : f_rol

    // Rotate right, carry fills the vacated high bits
    function automatic logic [31:0] f_ror(input logic [31:0] d, input logic [4:0] n,
                                          input logic c);
        return (d >> n) | (c ? ~(`CRCHR_ONES32 >> n) : `CRCHR_ZERO32);
    endfunction : f_ror

    crchr_pkg::crchr_state_t st_ff;
    crchr_pkg::crchr_state_t nxt_st;

    logic        awready_ff;
    logic        wready_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic [7:0]  awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic        arready_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;

    logic [31:0] instr_ff;
    logic [31:0] dval_ff;
    logic [31:0] sval_ff;
    logic [31:0] result_ff;
    logic [31:0] ctla_ff;
    logic [31:0] inca_ff;
    logic [31:0] ctlb_ff;
    logic [31:0] incb_ff;
    logic [31:0] shadow_ff [2];
    logic        c_ff;
    logic        z_ff;
    logic        err_ff;
    logic        wrote_ff;
    logic [31:0] src_ff;
    logic [31:0] dst_ff;
    logic [4:0]  cnt_ff;
    logic        got_ff;
    logic [31:0] hubval_ff;
    logic        hub_req_ff;
    logic [15:0] hub_addr_ff;
    logic        hub_long_ff;

    logic        do_wr;
    logic        busy;
    logic        wr_ok;
    logic        we;
    logic        go;
    logic [31:0] new_instr;
    logic [5:0]  new_op;
    logic        new_rot;
    logic        new_hub;
    logic [31:0] new_src;
    logic [31:0] new_dst;
    logic [31:0] rot_res;
    logic        fin;
    logic [31:0] fin_val;
    logic        wb;
    logic [8:0]  dfield;
    logic [31:0] rd_mux;

    crchr_ctr_if ca ();
    crchr_ctr_if cb ();

    // Two identical counter modules
    crchr_phase_ctr u_ctr_a (.aclk(aclk), .aresetn(aresetn), .port(ca.ctr));
    crchr_phase_ctr u_ctr_b (.aclk(aclk), .aresetn(aresetn), .port(cb.ctr));

    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign hub_req       = hub_req_ff;
    assign hub_addr      = hub_addr_ff;
    assign hub_long      = hub_long_ff;

    // Write side decode; writes while an instruction runs are refused
    assign busy      = (st_ff != crchr_pkg::CRCHR_ST_IDLE);
    assign do_wr     = !awready_ff && !wready_ff && !bvalid_ff;
    assign wr_ok     = f_mapped(awaddr_ff) && !busy && (awaddr_ff != `CRCHR_A_RESULT)
                       && (awaddr_ff != `CRCHR_A_STATUS);
    assign we        = do_wr && wr_ok;
    assign go        = we && (awaddr_ff == `CRCHR_A_INSTR);
    assign new_instr = f_merge(instr_ff, wdata_ff, wstrb_ff);
    assign new_op    = new_instr[`CRCHR_F_OP];
    assign new_rot   = (new_op == `CRCHR_OP_ROL) || (new_op == `CRCHR_OP_ROR);
    // The no-write form of a read would be a hub write, which is not built here
    assign new_hub   = ((new_op == `CRCHR_OP_RBYTE) || (new_op == `CRCHR_OP_RLONG))
                       && new_instr[`CRCHR_F_WR];

    // Source: literal or register; phase addresses read the live accumulator
    always_comb
    begin
        if (new_instr[`CRCHR_F_IM])
            new_src = {23'h000000, new_instr[`CRCHR_F_S]};
        else if (new_instr[`CRCHR_F_S] == `CRCHR_PHSA_ADR)
            new_src = ca.phs;
        else if (new_instr[`CRCHR_F_S] == `CRCHR_PHB_ADR)
            new_src = cb.phs;
        else
            new_src = sval_ff;
    end

    // Destination: phase addresses read their shadow, not the accumulator
    always_comb
    begin
        if (new_instr[`CRCHR_F_D] == `CRCHR_PHSA_ADR)
            new_dst = shadow_ff[0];
        else if (new_instr[`CRCHR_F_D] == `CRCHR_PHB_ADR)
            new_dst = shadow_ff[1];
        else
            new_dst = dval_ff;
    end

    // Rotate result from latched operands and the carry held since start
    assign rot_res = (instr_ff[`CRCHR_F_OP] == `CRCHR_OP_ROL)
                     ? f_rol(dst_ff, src_ff[`CRCHR_F_CNT], c_ff)
                     : f_ror(dst_ff, src_ff[`CRCHR_F_CNT], c_ff);

    // Completion: rotates after four clocks, reads after data and the floor
    assign fin = ((st_ff == crchr_pkg::CRCHR_ST_ROT) && (cnt_ff == `CRCHR_ROT_CLKS - 5'h01))
                 || ((st_ff == crchr_pkg::CRCHR_ST_HUB) && got_ff
                     && (cnt_ff >= `CRCHR_HUB_MIN - 5'h01));
    assign fin_val = (st_ff == crchr_pkg::CRCHR_ST_ROT) ? rot_res : hubval_ff;
    assign wb      = fin && ((st_ff == crchr_pkg::CRCHR_ST_HUB) || instr_ff[`CRCHR_F_WR]);
    assign dfield  = instr_ff[`CRCHR_F_D];

    // Counter links; software writes and write-back both load the accumulator
    assign ca.ctrl  = ctla_ff;
    assign ca.frq   = inca_ff;
    assign ca.wr    = (wb && dfield == `CRCHR_PHSA_ADR) || (we && awaddr_ff == `CRCHR_A_PHSA);
    assign ca.wdata = busy ? fin_val : f_merge(ca.phs, wdata_ff, wstrb_ff);
    assign cb.ctrl  = ctlb_ff;
    assign cb.frq   = incb_ff;
    assign cb.wr    = (wb && dfield == `CRCHR_PHB_ADR) || (we && awaddr_ff == `CRCHR_A_PHB);
    assign cb.wdata = busy ? fin_val : f_merge(cb.phs, wdata_ff, wstrb_ff);

    // Next state
    always_comb
    begin
        nxt_st = st_ff;
        unique case (st_ff)
            crchr_pkg::CRCHR_ST_IDLE:
            begin
                if (go && new_rot)
                    nxt_st = crchr_pkg::CRCHR_ST_ROT;
                else if (go && new_hub)
                    nxt_st = crchr_pkg::CRCHR_ST_HUB;
            end
            crchr_pkg::CRCHR_ST_ROT,
            crchr_pkg::CRCHR_ST_HUB:
            begin
                if (fin)
                    nxt_st = crchr_pkg::CRCHR_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_ff <= crchr_pkg::CRCHR_ST_IDLE;
        else
            st_ff <= nxt_st;
    end

    // Write address and data are taken independently and held until answered
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            awaddr_ff  <= 8'h00;
            wdata_ff   <= `CRCHR_ZERO32;
            wstrb_ff   <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && awready_ff)
            begin
                awready_ff <= 1'b0;
                awaddr_ff  <= s_axi_awaddr;
            end
            else if (bvalid_ff && s_axi_bready)
                awready_ff <= 1'b1;
            if (s_axi_wvalid && wready_ff)
            begin
                wready_ff <= 1'b0;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end
            else if (bvalid_ff && s_axi_bready)
                wready_ff <= 1'b1;
        end
    end

    // Write response one cycle after both halves are held
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= `CRCHR_RESP_OK;
        end
        else if (do_wr)
        begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_ok ? `CRCHR_RESP_OK : `CRCHR_RESP_ERR;
        end
        else if (bvalid_ff && s_axi_bready)
            bvalid_ff <= 1'b0;
    end

    // Read data mux; the phase offsets show the live accumulators
    always_comb
    begin
        rd_mux = `CRCHR_ZERO32;
        case (s_axi_araddr)
            `CRCHR_A_INSTR:  rd_mux = instr_ff;
            `CRCHR_A_DVAL:   rd_mux = dval_ff;
            `CRCHR_A_SVAL:   rd_mux = sval_ff;
            `CRCHR_A_FLAGS:  rd_mux = {30'h00000000, z_ff, c_ff};
            `CRCHR_A_RESULT: rd_mux = result_ff;
            `CRCHR_A_STATUS: rd_mux = {29'h00000000, wrote_ff, err_ff, busy};
            `CRCHR_A_CTLA:   rd_mux = ctla_ff;
            `CRCHR_A_INCA:   rd_mux = inca_ff;
            `CRCHR_A_CTLB:   rd_mux = ctlb_ff;
            `CRCHR_A_INCB:   rd_mux = incb_ff;
            `CRCHR_A_PHSA:   rd_mux = ca.phs;
            `CRCHR_A_PHB:    rd_mux = cb.phs;
            default:         rd_mux = `CRCHR_ZERO32;
        endcase
    end

    // Read channel: one read at a time, answered the cycle after address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= `CRCHR_ZERO32;
            rresp_ff   <= `CRCHR_RESP_OK;
        end
        else if (s_axi_arvalid && arready_ff)
        begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= rd_mux;
            rresp_ff   <= f_mapped(s_axi_araddr) ? `CRCHR_RESP_OK : `CRCHR_RESP_ERR;
        end
        else if (rvalid_ff && s_axi_rready)
        begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
        end
    end

    // Software-owned configuration registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            instr_ff <= `CRCHR_ZERO32;
            sval_ff  <= `CRCHR_ZERO32;
            ctla_ff  <= `CRCHR_ZERO32;
            inca_ff  <= `CRCHR_ZERO32;
            ctlb_ff  <= `CRCHR_ZERO32;
            incb_ff  <= `CRCHR_ZERO32;
        end
        else if (we)
        begin
            if (awaddr_ff == `CRCHR_A_INSTR) instr_ff <= new_instr;
            if (awaddr_ff == `CRCHR_A_SVAL)  sval_ff  <= f_merge(sval_ff, wdata_ff, wstrb_ff);
            if (awaddr_ff == `CRCHR_A_CTLA)  ctla_ff  <= f_merge(ctla_ff, wdata_ff, wstrb_ff);
            if (awaddr_ff == `CRCHR_A_INCA)  inca_ff  <= f_merge(inca_ff, wdata_ff, wstrb_ff);
            if (awaddr_ff == `CRCHR_A_CTLB)  ctlb_ff  <= f_merge(ctlb_ff, wdata_ff, wstrb_ff);
            if (awaddr_ff == `CRCHR_A_INCB)  incb_ff  <= f_merge(incb_ff, wdata_ff, wstrb_ff);
        end
    end

    // Destination register and shadows: software when idle, write-back when done
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dval_ff      <= `CRCHR_ZERO32;
            shadow_ff[0] <= `CRCHR_ZERO32;
            shadow_ff[1] <= `CRCHR_ZERO32;
        end
        else if (wb)
        begin
            if (dfield == `CRCHR_PHSA_ADR)
                shadow_ff[0] <= fin_val;
            else if (dfield == `CRCHR_PHB_ADR)
                shadow_ff[1] <= fin_val;
            else
                dval_ff <= fin_val;
        end
        else if (we)
        begin
            if (awaddr_ff == `CRCHR_A_DVAL)
                dval_ff <= f_merge(dval_ff, wdata_ff, wstrb_ff);
            if (awaddr_ff == `CRCHR_A_PHSA)
                shadow_ff[0] <= ca.wdata;
            if (awaddr_ff == `CRCHR_A_PHB)
                shadow_ff[1] <= cb.wdata;
        end
    end

    // Flags change at completion or by a software write while idle, so the rotate fill sees the old carry
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            c_ff <= 1'b0;
            z_ff <= 1'b0;
        end
        else if (fin)
        begin
            if (instr_ff[`CRCHR_F_ZE])
                z_ff <= (fin_val == `CRCHR_ZERO32);
            if (instr_ff[`CRCHR_F_CE] && st_ff == crchr_pkg::CRCHR_ST_HUB)
                c_ff <= 1'b0;
            else if (instr_ff[`CRCHR_F_CE] && instr_ff[`CRCHR_F_OP] == `CRCHR_OP_ROL)
                c_ff <= dst_ff[31];
            else if (instr_ff[`CRCHR_F_CE])
                c_ff <= dst_ff[0];
        end
        else if (we && awaddr_ff == `CRCHR_A_FLAGS && wstrb_ff[0])
        begin
            c_ff <= wdata_ff[`CRCHR_FLG_C];
            z_ff <= wdata_ff[`CRCHR_FLG_Z];
        end
    end

    // Operand capture at start keeps the run immune to accumulator motion
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            src_ff <= `CRCHR_ZERO32;
            dst_ff <= `CRCHR_ZERO32;
        end
        else if (go)
        begin
            src_ff <= new_src;
            dst_ff <= new_dst;
        end
    end

    // Cycle counter of the running instruction, saturating
    always_ff @(posedge aclk)
    begin
        if (!aresetn || go)
            cnt_ff <= 5'h00;
        else if (busy && cnt_ff != `CRCHR_CNT_MAX)
            cnt_ff <= cnt_ff + 5'h01;
    end

    // Hub request: raised at start, dropped at the grant pulse
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hub_req_ff  <= 1'b0;
            hub_addr_ff <= 16'h0000;
            hub_long_ff <= 1'b0;
        end
        else if (go && new_hub)
        begin
            hub_req_ff  <= 1'b1;
            hub_long_ff <= (new_op == `CRCHR_OP_RLONG);
            if (new_op == `CRCHR_OP_RLONG)
                hub_addr_ff <= {new_src[15:2], 2'h0};
            else
                hub_addr_ff <= new_src[15:0];
        end
        else if (hub_req_ff && hub_gnt)
            hub_req_ff <= 1'b0;
    end

    // Hub data capture; bytes are zero-extended
    always_ff @(posedge aclk)
    begin
        if (!aresetn || go)
        begin
            got_ff    <= 1'b0;
            hubval_ff <= `CRCHR_ZERO32;
        end
        else if (hub_req_ff && hub_gnt)
        begin
            got_ff    <= 1'b1;
            hubval_ff <= hub_long_ff ? hub_rdata : {24'h000000, hub_rdata[7:0]};
        end
    end

    // Status: last result, refusal of an unknown instruction, write-back seen
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            result_ff <= `CRCHR_ZERO32;
            err_ff    <= 1'b0;
            wrote_ff  <= 1'b0;
        end
        else if (fin)
        begin
            result_ff <= fin_val;
            wrote_ff  <= wb;
        end
        else if (go)
        begin
            err_ff   <= !(new_rot || new_hub);
            wrote_ff <= 1'b0;
        end
    end

endmodule : crchr_top

/* crchr_top_properties.sv */
/* Port checks: AXI handshakes and hub requests.
   Assumes a bind into crchr_top by port name. */
`timescale 1ns/100ps
module crchr_top_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        hub_req,
    input wire logic [15:0] hub_addr,
    input wire logic        hub_long,
    input wire logic        hub_gnt
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Request awaiting its slot
    sequence s_wait;
        hub_req && !hub_gnt;
    endsequence
    a_req_holds: assert property (s_wait |=> hub_req && $stable({hub_addr, hub_long}))
        else $error("hub request moved");
    a_req_ends: assert property (hub_req && hub_gnt |=> !hub_req)
        else $error("hub request stuck");
    a_long_align: assert property (hub_req && hub_long |-> hub_addr[1:0] == 2'h0)
        else $error("long address unaligned");
    a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_b_ends: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
        else $error("write answer stuck");
    a_b_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write slot open early");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data moved");
endmodule : crchr_top_chk

bind crchr_top crchr_top_chk u_chk (.*);

/* crchr_hub_model.sv */
/* Hub model: delayed grant, patterned data.
   Assumes the request holds until granted. */
`timescale 1ns/100ps
module crchr_hub_model (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        hub_req,
    input wire logic [15:0] hub_addr,
    input wire logic        hub_long,
    input wire logic [4:0]  hub_dly,
    output logic            hub_gnt,
    output logic [31:0]     hub_rdata
);
    logic [4:0]  wait_ff;
    logic [31:0] junk_ff;
    // Moving junk so stale data never looks valid
    always_ff @(posedge aclk)
    begin
        junk_ff <= aresetn ? junk_ff + 32'h9e37_79b9 : 32'h0;
        wait_ff <= (aresetn && hub_req && !hub_gnt) ? wait_ff + 5'h01 : 5'h00;
    end
    // Grant after hub_dly waits
    assign hub_gnt   = hub_req && wait_ff == hub_dly;
    assign hub_rdata = !hub_gnt ? junk_ff : hub_long ? {hub_addr, ~hub_addr} : {24'h5a5a5a, hub_addr[7:0]};
endmodule : crchr_hub_model

/* tb_cog_rotate_carry_hub_read.sv */
/* Bench: AXI4-Lite tasks, rotate, phase and hub runs.
   Assumes the hub model. */
`timescale 1ns/100ps
module tb_cog_rotate_carry_hub_read;
    logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, hub_req, hub_long, hub_gnt;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, hub_rdata, r, v, w;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, br;
    logic [15:0] hub_addr, a;
    logic [8:0]  sf;
    logic [4:0]  hub_dly = '0, n;
    logic [4:0]  cnt_tab [8] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h1f, 5'h04, 5'h02, 5'h1f};
    int          num_errors = 0, comparisons = 0, cyc = 0;

    crchr_top dut_u (.*);
    crchr_hub_model hub_u (.*);

    always #5 aclk = ~aclk;
    // Hang guard, far above run length
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            end_sim();
        end
    end

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e)
        begin
            num_errors++;
            $display("Error %s exp %h got %h", nm, e, s);
        end
    endtask : chk

    // aw and w offered together
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {ad, d, 3'h7};
        do
        begin
            @(posedge aclk);
            s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
            s_axi_wvalid  <= s_axi_wvalid && !s_axi_wready;
        end
        while (!s_axi_bvalid);
        br = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] ad, output logic [31:0] d);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {ad, 2'h3};
        do
        begin
            @(posedge aclk);
            s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
        end
        while (!s_axi_rvalid);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask : rd

    // Start, then poll busy
    task automatic run(input logic [31:0] i);
        wr(8'h00, i);
        do
            rd(8'h14, r);
        while (r[0] !== 1'b0);
    endtask : run

    function automatic logic [31:0] rot(input logic rt, input logic [31:0] d, input logic [4:0] k, input logic c);
        for (int i = 0; i < k; i++)
            d = rt ? {c, d[31:1]} : {d[30:0], c};
        return d;
    endfunction : rot

    task end_sim;
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        // Rotates, both ways and count sources
        for (int k = 0; k < 8; k++)
        begin
            n = cnt_tab[k];
            v = (k == 4) ? 32'h0 : 32'h8765_4321 ^ k;
            w = rot(k[0], v, n, k[1]);
            wr(8'h08, 32'hffff_ffe0 | n);
            wr(8'h04, v);
            wr(8'h0c, 32'h2 | k[1]);
            run({5'h06, ~k[0], 2'h3, k != 5, k[2], 4'hf, 9'h0, k[2] ? {4'h0, n} : 9'h0});
            rd(8'h04, r);
            chk("dval", r, (k == 5) ? v : w);
            rd(8'h0c, r);
            chk("flags", r, {30'h0, w == 0, k[0] ? v[0] : v[31]});
        end
        $display("rotate test done");
        // Phase: counter run after the phase write, then stopped
        wr(8'h1c, 32'h1);
        wr(8'h18, 32'h0400_0000);
        wr(8'h28, 32'h100);
        wr(8'h18, 32'h0);
        rd(8'h28, r);
        chk("phase_live", {31'h0, r > 32'h100}, 32'h1);
        wr(8'h0c, 32'h1);
        run({6'h0d, 4'h3, 4'hf, 9'h1fc, 9'h001});
        rd(8'h10, r);
        chk("phase_shadow", r, 32'h201);
        rd(8'h28, r);
        chk("phase_wb", r, 32'h201);
        $display("phase test done");
        // Hub reads, both sizes and sources
        for (int k = 0; k < 4; k++)
        begin
            sf = k[0] ? 9'h1a7 : 9'h1a3;
            v = k[0] ? 32'habcd_1235 : 32'h0000_1200;
            a = k[1] ? v[15:0] : {7'h0, sf};
            a[1:0] = k[0] ? 2'h0 : a[1:0];
            w = k[0] ? {a, ~a} : {24'h0, a[7:0]};
            hub_dly <= 5'(k * 6);
            wr(8'h08, v);
            wr(8'h0c, 32'h1);
            run({4'h0, k[0], 4'h7, ~k[1], 4'hf, 9'h0, sf});
            rd(8'h04, r);
            chk("hub_data", r, w);
            rd(8'h0c, r);
            chk("hub_flags", r, {30'h0, w == 0, 1'b0});
        end
        run({6'h02, 4'hc, 4'hf, 18'h0});
        rd(8'h14, r);
        chk("read_no_store", {31'h0, r[1]}, 32'h1);
        wr(8'h10, 32'h0);
        chk("ro_write", {30'h0, br}, 32'h2);
        $display("hub test done");
        end_sim();
    end
endmodule : tb_cog_rotate_carry_hub_read
